// [rtl/timer2_pkg.sv]
// Constants and types shared by the timer 2 block
package timer2_pkg;
	localparam int          ADDR_WIDTH     = 10;
	localparam int          DATA_WIDTH     = 32;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_CONTROL    = 8'hc8;
	localparam logic [7:0]  IDX_MODE       = 8'hc9;
	localparam logic [7:0]  IDX_CAP_LOW    = 8'hca;
	localparam logic [7:0]  IDX_CAP_HIGH   = 8'hcb;
	localparam logic [7:0]  IDX_COUNT_LOW  = 8'hcc;
	localparam logic [7:0]  IDX_COUNT_HIGH = 8'hcd;
	localparam logic [7:0]  CONTROL_RESET  = 8'h00;
	localparam logic        MODE_RESET     = 1'b0;
	localparam logic [15:0] CAP_RESET      = 16'h0000;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
	localparam int          MODE_DOWN_COUNT_ENABLE_BIT  = 0;
	// Core clocks per machine cycle in timer operation
	localparam logic [3:0]  MACHINE_CLOCKS = 4'hc;

	// Control register, bit 7 first
	typedef struct packed {
		logic overflow_flag;
		logic external_flag;
		logic rx_baud_source_select;
		logic tx_baud_source_select;
		logic ext_trigger_enable;
		logic run_control;
		logic counter_select;
		logic capture_reload_select;
	} control_type;
endpackage

// [rtl/timer2_capture_reload_baud.sv]
// Timer 2: capture, auto-reload and baud generation with Avalon-MM slave
`timescale 1ns/100ps
module timer2_capture_reload_baud (
	input  wire logic                               ref_clk,
	input  wire logic                               rst,
	input  wire logic [timer2_pkg::ADDR_WIDTH-1:0]  address,
	input  wire logic                               read,
	input  wire logic                               write,
	input  wire logic [timer2_pkg::DATA_WIDTH-1:0]  writedata,
	input  wire logic [3:0]                         byteenable,
	output logic      [timer2_pkg::DATA_WIDTH-1:0]  readdata,
	output logic                                    waitrequest,
	input  wire logic                               ext_trigger_pin,
	input  wire logic                               ext_count_pin,
	input  wire logic                               timer1_overflow,
	input  wire logic                               timer_irq_enable,
	output logic                                    timer_irq,
	output logic                                    rx_baud_tick,
	output logic                                    tx_baud_tick
);
	import timer2_pkg::*;

	control_type ctl_reg;
	logic        down_count_enable_reg;
	logic [15:0] cap_reg;
	logic [15:0] count_reg;
	logic [3:0]  mc_cnt_reg;
	logic        trig_prev_reg;
	logic        cnt_prev_reg;
	logic        ack_reg;
	logic [31:0] readdata_reg;
	logic        irq_reg;
	logic        rx_tick_reg;
	logic        tx_tick_reg;

	logic        baud;
	logic        mc_tick;
	logic        ext_fall;
	logic        cnt_fall;
	logic        up_down_mode;
	logic        count_down;
	logic        tick;
	logic        overflow_up;
	logic        underflow;
	logic        ext_event;
	logic        reload;
	logic        capture;
	logic        wr_hit;
	logic [7:0]  idx;
	logic        wr_ctl;
	logic        wr_mode;
	logic        wr_cap_low;
	logic        wr_cap_high;
	logic        wr_cnt_low;
	logic        wr_cnt_high;
	logic        of_base;
	logic        ef_base;

	// Avalon slave: one wait cycle, answer registered
	assign idx         = address[ADDR_WIDTH-1:2];
	assign waitrequest = (read | write) & ~ack_reg;
	assign wr_hit      = write & ack_reg & byteenable[0];
	assign wr_ctl      = wr_hit & (idx == IDX_CONTROL);
	assign wr_mode     = wr_hit & (idx == IDX_MODE);
	assign wr_cap_low  = wr_hit & (idx == IDX_CAP_LOW);
	assign wr_cap_high = wr_hit & (idx == IDX_CAP_HIGH);
	assign wr_cnt_low  = wr_hit & (idx == IDX_COUNT_LOW);
	assign wr_cnt_high = wr_hit & (idx == IDX_COUNT_HIGH);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read | write) & ~ack_reg;
		end
	end

	// Unmapped indices read as zero; upper bytes always zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			readdata_reg <= 32'h0;
		end else if (read & ~ack_reg) begin
			unique case (idx)
				IDX_CONTROL:    readdata_reg <= {24'h0, ctl_reg};
				IDX_MODE:       readdata_reg <= {31'h0, down_count_enable_reg};
				IDX_CAP_LOW:    readdata_reg <= {24'h0, cap_reg[7:0]};
				IDX_CAP_HIGH:   readdata_reg <= {24'h0, cap_reg[15:8]};
				IDX_COUNT_LOW:  readdata_reg <= {24'h0, count_reg[7:0]};
				IDX_COUNT_HIGH: readdata_reg <= {24'h0, count_reg[15:8]};
				default:        readdata_reg <= 32'h0;
			endcase
		end
	end
	assign readdata = readdata_reg;

	// Prescaler: 12 is even, so bit 0 alternates every clock
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mc_cnt_reg <= 4'h0;
		end else if (mc_tick) begin
			mc_cnt_reg <= 4'h0;
		end else begin
			mc_cnt_reg <= mc_cnt_reg + 4'h1;
		end
	end
	assign mc_tick = (mc_cnt_reg == MACHINE_CLOCKS - 4'h1);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			trig_prev_reg <= 1'b0;
			cnt_prev_reg  <= 1'b0;
		end else begin
			trig_prev_reg <= ext_trigger_pin;
			cnt_prev_reg  <= ext_count_pin;
		end
	end
	assign ext_fall = trig_prev_reg & ~ext_trigger_pin;
	assign cnt_fall = cnt_prev_reg & ~ext_count_pin;

	assign baud = ctl_reg.rx_baud_source_select
		| ctl_reg.tx_baud_source_select;
	assign up_down_mode = down_count_enable_reg & ~baud
		& ~ctl_reg.capture_reload_select;
	assign count_down = up_down_mode & ~ext_trigger_pin;
	assign tick = ctl_reg.run_control & (baud ? mc_cnt_reg[0]
		: (ctl_reg.counter_select ? cnt_fall : mc_tick));
	assign overflow_up = tick & ~count_down
		& (count_reg == COUNT_ALL_ONES);
	assign underflow = tick & count_down & (count_reg == cap_reg);
	// Direction mode takes the pin as a level, so its edges do nothing
	assign ext_event = ctl_reg.ext_trigger_enable & ~baud
		& ~up_down_mode & ext_fall;
	assign reload = (ext_event & ~ctl_reg.capture_reload_select)
		| (overflow_up & (baud | ~ctl_reg.capture_reload_select));
	assign capture = ext_event & ctl_reg.capture_reload_select;

	// Counter: hardware events first, software write only in a cycle without one
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_reg <= COUNT_RESET;
		end else if (underflow) begin
			count_reg <= COUNT_ALL_ONES;
		end else if (reload) begin
			count_reg <= cap_reg;
		end else if (tick) begin
			count_reg <= count_down ? count_reg - 16'h1
				: count_reg + 16'h1;
		end else begin
			if (wr_cnt_low) begin
				count_reg[7:0] <= writedata[7:0];
			end
			if (wr_cnt_high) begin
				count_reg[15:8] <= writedata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cap_reg <= CAP_RESET;
		end else if (capture) begin
			cap_reg <= count_reg;
		end else begin
			if (wr_cap_low) begin
				cap_reg[7:0] <= writedata[7:0];
			end
			if (wr_cap_high) begin
				cap_reg[15:8] <= writedata[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			down_count_enable_reg <= MODE_RESET;
		end else if (wr_mode) begin
			down_count_enable_reg <= writedata[MODE_DOWN_COUNT_ENABLE_BIT];
		end
	end

	// Flags: a hardware set wins over a software clear in the same cycle
	assign of_base = wr_ctl ? writedata[7] : ctl_reg.overflow_flag;
	assign ef_base = wr_ctl ? writedata[6] : ctl_reg.external_flag;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctl_reg <= CONTROL_RESET;
		end else begin
			if (wr_ctl) begin
				ctl_reg[5:0] <= writedata[5:0];
			end
			ctl_reg.overflow_flag <= of_base
				| ((overflow_up | underflow) & ~baud);
			if (ext_event) begin
				ctl_reg.external_flag <= 1'b1;
			end else if ((overflow_up | underflow) & up_down_mode) begin
				ctl_reg.external_flag <= ~ef_base;
			end else begin
				ctl_reg.external_flag <= ef_base;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= timer_irq_enable & (ctl_reg.overflow_flag
				| ctl_reg.external_flag);
		end
	end
	assign timer_irq = irq_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_tick_reg <= 1'b0;
			tx_tick_reg <= 1'b0;
		end else begin
			rx_tick_reg <= ctl_reg.rx_baud_source_select
				? overflow_up : timer1_overflow;
			tx_tick_reg <= ctl_reg.tx_baud_source_select
				? overflow_up : timer1_overflow;
		end
	end
	assign rx_baud_tick = rx_tick_reg;
	assign tx_baud_tick = tx_tick_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence bus_request;
		(read | write) & ~ack_reg;
	endsequence
	sequence read_taken;
		read & ~waitrequest;
	endsequence

	bus_answer_a: assert property (bus_request |=> ~waitrequest)
		else $error("Bus request not answered after one wait");
	read_data_a: assert property (read & ~ack_reg & (idx == IDX_CONTROL)
		##1 read_taken |-> readdata[7:0] == $past(ctl_reg))
		else $error("Control readback wrong");
	overflow_set_a: assert property (overflow_up & ~baud
		|=> ctl_reg.overflow_flag)
		else $error("Overflow did not set flag");
	down_match_a: assert property (underflow & ~baud
		|=> ctl_reg.overflow_flag && count_reg == COUNT_ALL_ONES)
		else $error("Down-count match mishandled");
	baud_flag_a: assert property (baud & ~wr_ctl
		|=> ctl_reg.overflow_flag == $past(ctl_reg.overflow_flag))
		else $error("Flag changed in baud operation");
	flag_hold_a: assert property (ctl_reg.overflow_flag & ~wr_ctl
		|=> ctl_reg.overflow_flag)
		else $error("Hardware cleared overflow flag");
	ext_set_a: assert property (ext_event |=> ctl_reg.external_flag)
		else $error("Trigger edge did not set external flag");
	irq_raise_a: assert property (ctl_reg.external_flag
		& timer_irq_enable |=> timer_irq)
		else $error("Interrupt not raised");
	tx_source_a: assert property (~ctl_reg.tx_baud_source_select
		|=> tx_baud_tick == $past(timer1_overflow))
		else $error("Transmit source not timer 1");
	run_hold_a: assert property (~ctl_reg.run_control & ~ext_event
		& ~wr_cnt_low & ~wr_cnt_high |=> $stable(count_reg))
		else $error("Stopped count changed");
	baud_rate_a: assert property (baud & ctl_reg.run_control
		& ~reload & ~wr_cnt_low & ~wr_cnt_high & tick |=> ~tick)
		else $error("Baud count faster than every 2 clocks");
	capture_a: assert property (capture |=> cap_reg == $past(count_reg))
		else $error("Capture lost count");
	reload_a: assert property (reload |=> count_reg == $past(cap_reg))
		else $error("Reload value wrong");
endmodule

// [tb/far_model.sv]
// Far-side model: trigger and count pins, timer 1 overflow, tick counters
`timescale 1ns/100ps
module far_model (
	input  wire logic ref_clk,
	input  wire logic rx_baud_tick,
	input  wire logic tx_baud_tick,
	output logic      ext_trigger_pin,
	output logic      ext_count_pin,
	output logic      timer1_overflow
);
	int rx_ticks = 0;
	int tx_ticks = 0;
	initial begin
		ext_trigger_pin = 1'b1;
		ext_count_pin   = 1'b1;
		timer1_overflow = 1'b0;
	end
	always @(posedge ref_clk) begin
		rx_ticks <= rx_ticks + int'(rx_baud_tick === 1'b1);
		tx_ticks <= tx_ticks + int'(tx_baud_tick === 1'b1);
	end
	// Three cycles low so the sampler sees high then low
	task fall(input bit trig);
		@(posedge ref_clk);
		if (trig)
			ext_trigger_pin <= 1'b0;
		else
			ext_count_pin <= 1'b0;
		repeat (3) @(posedge ref_clk);
		ext_trigger_pin <= 1'b1;
		ext_count_pin   <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask
	task set_trig(input bit v);
		@(posedge ref_clk);
		ext_trigger_pin <= v;
	endtask
	task t1_pulse;
		@(posedge ref_clk);
		timer1_overflow <= 1'b1;
		@(posedge ref_clk);
		timer1_overflow <= 1'b0;
	endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the timer 2 block
`timescale 1ns/100ps
module tb_top;
	import timer2_pkg::*;
	logic                  ref_clk = 1'b0;
	logic                  rst = 1'b1;
	logic [ADDR_WIDTH-1:0] address = '0;
	logic                  read = 1'b0;
	logic                  write = 1'b0;
	logic [DATA_WIDTH-1:0] writedata = '0;
	logic [DATA_WIDTH-1:0] readdata;
	logic                  waitrequest, trig, cnt, t1_ovf, irq, rx_t, tx_t;
	logic                  irq_en = 1'b0;
	logic [3:0]            byteenable = 4'hf;
	logic [3:0]            be_sel = 4'hf;
	logic [7:0]            q;
	int                    bad_count = 0;
	int                    check_count = 0;
	int                    r0, t0;
	initial forever #4 ref_clk = ~ref_clk;
	timer2_capture_reload_baud u_timer2_capture_reload_baud (
		.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.ext_trigger_pin(trig), .ext_count_pin(cnt),
		.timer1_overflow(t1_ovf), .timer_irq_enable(irq_en),
		.timer_irq(irq), .rx_baud_tick(rx_t), .tx_baud_tick(tx_t));
	far_model u_far_model (
		.ref_clk(ref_clk), .rx_baud_tick(rx_t), .tx_baud_tick(tx_t),
		.ext_trigger_pin(trig), .ext_count_pin(cnt),
		.timer1_overflow(t1_ovf));
	task check(input string what, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	// Request stands until waitrequest is sampled low at a rising edge
	task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		read       <= !wr;
		write      <= wr;
		address    <= {idx, 2'b00};
		writedata  <= {24'h0, d};
		byteenable <= be_sel;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0);
		check("wait cycles", 8'h2, n[7:0]);
		q = readdata[7:0];
		read  <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task rd(input string what, input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h0);
		check(what, e, q);
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task t_reset;
		rd("control", IDX_CONTROL, CONTROL_RESET);
		rd("count low", IDX_COUNT_LOW, COUNT_RESET[7:0]);
		rd("unmapped", 8'hc7, 8'h00);
		// Byte lane 0 off: the write must be dropped
		be_sel = 4'he;
		wr(IDX_CAP_LOW, 8'h5a);
		be_sel = 4'hf;
		rd("masked write", IDX_CAP_LOW, CAP_RESET[7:0]);
	endtask
	task t_soft;
		wr(IDX_CONTROL, 8'h40);
		@(posedge ref_clk);
		irq_en <= 1'b1;
		wait_n(3);
		@(negedge ref_clk);
		check("irq", 8'h1, {7'h0, irq});
		@(posedge ref_clk);
		irq_en <= 1'b0;
		wait_n(3);
		@(negedge ref_clk);
		check("irq masked", 8'h0, {7'h0, irq});
		wr(IDX_CONTROL, 8'h80);
		rd("sw set", IDX_CONTROL, 8'h80);
		wr(IDX_CONTROL, 8'h00);
		rd("sw clear", IDX_CONTROL, 8'h00);
	endtask
	task t_reload;
		wr(IDX_CAP_LOW, 8'h34);
		wr(IDX_CAP_HIGH, 8'h12);
		wr(IDX_COUNT_LOW, 8'hfe);
		wr(IDX_COUNT_HIGH, 8'hff);
		wr(IDX_CONTROL, 8'h04);
		wait_n(60);
		rd("overflow", IDX_CONTROL, 8'h84);
		rd("reload high", IDX_COUNT_HIGH, 8'h12);
		wr(IDX_CONTROL, 8'h80);
		bus(1'b0, IDX_COUNT_LOW, 8'h00);
		r0 = q;
		rd("halted high", IDX_COUNT_HIGH, 8'h12);
		wait_n(30);
		rd("held", IDX_COUNT_LOW, r0[7:0]);
		// Stopped, so only the trigger edge can move the count
		wr(IDX_CONTROL, 8'h08);
		u_far_model.fall(1'b1);
		rd("edge reload", IDX_COUNT_LOW, 8'h34);
		rd("edge flag", IDX_CONTROL, 8'h48);
		wr(IDX_CONTROL, 8'h00);
	endtask
	task t_capture;
		wr(IDX_COUNT_LOW, 8'h05);
		wr(IDX_COUNT_HIGH, 8'h00);
		wr(IDX_CONTROL, 8'h0f);
		repeat (3) u_far_model.fall(1'b0);
		rd("events", IDX_COUNT_LOW, 8'h08);
		u_far_model.fall(1'b1);
		wait_n(20);
		rd("cap low", IDX_CAP_LOW, 8'h08);
		rd("cap high", IDX_CAP_HIGH, 8'h00);
		rd("ext flag", IDX_CONTROL, 8'h4f);
		wr(IDX_CONTROL, 8'h07);
		u_far_model.fall(1'b1);
		rd("ignored", IDX_CONTROL, 8'h07);
		wr(IDX_CONTROL, 8'h00);
	endtask
	task t_down;
		wr(IDX_MODE, 8'h01);
		wr(IDX_CAP_LOW, 8'h00);
		wr(IDX_CAP_HIGH, 8'h00);
		wr(IDX_COUNT_LOW, 8'h02);
		wr(IDX_COUNT_HIGH, 8'h00);
		u_far_model.set_trig(1'b0);
		wr(IDX_CONTROL, 8'h04);
		wait_n(60);
		rd("down match", IDX_CONTROL, 8'hc4);
		rd("down wrap", IDX_COUNT_HIGH, 8'hff);
		wr(IDX_CONTROL, 8'h00);
		u_far_model.set_trig(1'b1);
		wr(IDX_MODE, 8'h00);
	endtask
	task t_baud;
		wr(IDX_CAP_LOW, 8'hfe);
		wr(IDX_CAP_HIGH, 8'hff);
		wr(IDX_COUNT_LOW, 8'hfe);
		wr(IDX_COUNT_HIGH, 8'hff);
		r0 = u_far_model.rx_ticks;
		t0 = u_far_model.tx_ticks;
		wr(IDX_CONTROL, 8'h25);
		repeat (5) u_far_model.t1_pulse;
		wait_n(30);
		rd("no flag", IDX_CONTROL, 8'h25);
		wr(IDX_CONTROL, 8'h00);
		r0 = u_far_model.rx_ticks - r0;
		t0 = u_far_model.tx_ticks - t0;
		// Four clocks per overflow with reload fffe, so about ten ticks
		check("rx ticks", 8'h1, {7'h0, r0 inside {[9:13]}});
		check("tx ticks", 8'h5, t0[7:0]);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#400000;
		bad_count++;
		finish_test;
	end
	initial begin
		wait_n(2);
		rst <= 1'b0;
		wait_n(1);
		t_reset;
		t_soft;
		t_reload;
		t_capture;
		t_down;
		t_baud;
		finish_test;
	end
endmodule
